// >>> hdl/spm_pkg.sv
package spm_pkg;

	// ----------------------------------------------------------------
	// I/O port map
	// ----------------------------------------------------------------
	localparam logic [9:0] ADDR_BASE = 10'h3F8; // Receive/transmit or divisor low
	localparam logic [9:0] ADDR_IER  = 10'h3F9; // Interrupt enable or divisor high
	localparam logic [9:0] ADDR_LCR  = 10'h3FB;
	localparam logic [9:0] ADDR_MCR  = 10'h3FC;
	localparam logic [9:0] ADDR_LSR  = 10'h3FD;
	localparam logic [9:0] ADDR_MSR  = 10'h3FE;
	localparam logic [7:0] UNMAPPED  = 8'hFF;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int LCR_STOP2  = 2;
	localparam int LCR_PAR_EN = 3;
	localparam int LCR_EVEN   = 4;
	localparam int LCR_STICK  = 5;
	localparam int LCR_BREAK  = 6;
	localparam int LCR_DLS    = 7; // divisor_latch_select
	localparam int MCR_DTR    = 0;
	localparam int MCR_RTS    = 1;
	localparam int MCR_AUX1   = 2; // aux_output_one
	localparam int MCR_AUX2   = 3;
	localparam int MCR_LOOP   = 4;
	localparam int IER_MODEM  = 3;
	// Modem level / change bit order: clear to send, set ready, ring, carrier
	localparam int M_CTS      = 0;
	localparam int M_DSR      = 1;
	localparam int M_RING     = 2;
	localparam int M_CARRIER  = 3;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [7:0]  LCR_RST      = 8'h00;
	localparam logic [4:0]  MCR_RST      = 5'h00;
	localparam logic [3:0]  IER_RST      = 4'h0;
	localparam logic [15:0] DIV_RST      = 16'h0000; // Zero halts the baud generator
	localparam int          CLK_HZ       = 32'h05F5_E100; // 100 MHz system clock
	localparam int          REF_HZ       = 32'h001C_2000; // 1.8432 MHz baud reference
	localparam logic [27:0] ACC_INC      = 28'(REF_HZ);
	localparam logic [27:0] ACC_WRAP     = 28'(CLK_HZ);
	localparam logic [3:0]  TICK_LAST    = 4'hF; // 16 divided 16x-rate ticks per bit
	localparam logic [3:0]  TICK_MID     = 4'h7;
	localparam int          TX_FIFO_DEPTH = 4;

	// ----------------------------------------------------------------
	// State machines
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SER_IDLE   = 3'b000,
		SER_START  = 3'b001,
		SER_DATA   = 3'b010,
		SER_PARITY = 3'b011,
		SER_STOP   = 3'b100
	} spm_ser_state_e;

endpackage

// >>> hdl/spm_uart.sv
`timescale 1ns/1ps
// What this block does
// - Modem input change sets matching change flag, ring only when it drops
// - Status register read clears all change flags
// - Bit 0 flags clear-to-send change
// - Bit 1 flags set-ready change
// - Bit 2 sets only on ring falling off
// - Bit 3 flags carrier detect change
// - Any change flag raises modem interrupt
// - Bits 4-7 show inverted modem input levels
// - Loopback: bits 4-7 show modem control outputs
// - Receive buffer holds character, first bit LSB
// - Transmitter sends holding byte LSB first
// - Select low: base port is receive/transmit
// - Line control bit 7 selects divisor latches
// - Divisor low at base, high at base+1
// - Divisor 12 gives 9600 baud from reference
// - Word length bits both set: 8 bits
// - Parity bit 3 off: no parity, 4-5 ignored
// - Line control bit 6 forces break
// - Written byte goes out asynchronously
// - Interrupt enable bit 3 gates modem interrupt
// - Loopback: change flags driven by modem control

// ------------------------------------------------------------------
// Transmit FIFO
// ------------------------------------------------------------------
module spm_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = spm_pkg::TX_FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             resetn_i,
	// Fill side
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	// Drain side
	output logic                  out_valid_o,
	output logic [WIDTH-1:0]      out_data_o,
	input  wire logic             out_ready_i
);
	localparam int          AW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wp;
		logic [AW-1:0]               rp;
		logic [AW:0]                 cnt;
	} spm_fifo_s;

	spm_fifo_s s_r;
	spm_fifo_s s_nxt;
	logic      push;
	logic      pop;

	// Handshakes; honest full and empty from the count
	assign in_ready_o  = (s_r.cnt != FULL);
	assign out_valid_o = (s_r.cnt != '0);
	assign out_data_o  = s_r.mem[s_r.rp];
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;

	// Pointer and count update; pointers wrap for any depth
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data_i;
			s_nxt.wp          = (s_r.wp == LAST) ? '0 : s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = (s_r.rp == LAST) ? '0 : s_r.rp + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

endmodule

// ------------------------------------------------------------------
// Serial port with modem status
// ------------------------------------------------------------------
module spm_uart (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       resetn_i,
	// CPU byte-wide I/O port
	input  wire logic [9:0] io_addr_i,
	input  wire logic       io_rd_i,
	input  wire logic       io_wr_i,
	input  wire logic [7:0] io_wdata_i,
	output logic      [7:0] io_rdata_o,
	output logic            io_rvalid_o,
	// Serial data
	input  wire logic       rxd_i,
	output logic            txd_o,
	// Modem inputs, active low
	input  wire logic       clear_to_send_n_i,
	input  wire logic       set_ready_n_i,
	input  wire logic       ring_n_i,
	input  wire logic       carrier_detect_n_i,
	// Modem outputs, active low
	output logic            request_to_send_n_o,
	output logic            terminal_ready_n_o,
	output logic            aux_output_one_n_o,
	output logic            aux_output_two_n_o,
	// Interrupt
	output logic            modem_irq_o
);
	typedef struct packed {
		logic [3:0]              msync1;
		logic [3:0]              msync2;
		logic                    rx_s1;
		logic                    rx_s2;
		logic [3:0]              mlvl;
		logic [3:0]              mdelta;
		logic [7:0]              lcr;
		logic [4:0]              modem_control;
		logic [3:0]              ier;
		logic [15:0]             div;
		logic [26:0]             acc;
		logic [15:0]             bcnt;
		logic [7:0]              receive_buffer;
		logic                    dr;
		logic                    oe;
		logic                    pe;
		logic                    fe;
		logic                    bi;
		spm_pkg::spm_ser_state_e tx_st;
		logic [3:0]              tx_cnt;
		logic [3:0]              tx_bits;
		logic [7:0]              tx_shift;
		logic                    tx_pbit;
		spm_pkg::spm_ser_state_e rx_st;
		logic [3:0]              rx_cnt;
		logic [3:0]              rx_bits;
		logic [7:0]              rx_shift;
		logic                    rx_par;
		logic                    rx_perr;
		logic [7:0]              rdata;
		logic                    rvalid;
		logic                    txd;
		logic                    irq;
		logic [3:0]              mout_n;
	} spm_uart_s;

	spm_uart_s   s_r;
	spm_uart_s   s_nxt;
	logic        f_valid;
	logic        f_ready;
	logic        f_take;
	logic [7:0]  f_data;
	logic        thr_wr;
	logic        dls;
	logic        rd_msr;
	logic [3:0]  ev;
	logic        b16;
	logic        tx_line;
	logic        rx_in;
	logic [3:0]  nbits;
	logic [7:0]  wmask;
	logic [27:0] acc_sum;

	assign dls    = s_r.lcr[spm_pkg::LCR_DLS];
	assign thr_wr = io_wr_i && (io_addr_i == spm_pkg::ADDR_BASE) && !dls;
	assign rd_msr = io_rd_i && (io_addr_i == spm_pkg::ADDR_MSR);
	assign nbits  = 4'd5 + {2'b00, s_r.lcr[1:0]};
	assign wmask  = 8'hFF >> (4'd8 - nbits);

	// ------------------------------------------------------------------
	// Transmit holding FIFO; a full FIFO drops the write and shows not-empty
	// ------------------------------------------------------------------
	spm_fifo #(
		.WIDTH (8),
		.DEPTH (spm_pkg::TX_FIFO_DEPTH)
	) u_tx_fifo (
		.sys_clk_i   (sys_clk_i),
		.resetn_i    (resetn_i),
		.in_valid_i  (thr_wr),
		.in_data_i   (io_wdata_i),
		.in_ready_o  (f_ready),
		.out_valid_o (f_valid),
		.out_data_o  (f_data),
		.out_ready_i (f_take)
	);

	// Next-state logic for the whole port
	always_comb begin
		s_nxt   = s_r;
		b16     = 1'b0;
		f_take  = 1'b0;
		acc_sum = {1'b0, s_r.acc} + spm_pkg::ACC_INC;

		// Pins pass two flops before anyone looks at them
		s_nxt.msync1 = {carrier_detect_n_i, ring_n_i, set_ready_n_i, clear_to_send_n_i};
		s_nxt.msync2 = s_r.msync1;
		s_nxt.rx_s1  = rxd_i;
		s_nxt.rx_s2  = s_r.rx_s1;

		// Modem levels: inverted pins, or control bits in loopback
		if (s_r.modem_control[spm_pkg::MCR_LOOP]) begin
			s_nxt.mlvl = {s_r.modem_control[spm_pkg::MCR_AUX2], s_r.modem_control[spm_pkg::MCR_AUX1],
				s_r.modem_control[spm_pkg::MCR_DTR], s_r.modem_control[spm_pkg::MCR_RTS]};
		end else begin
			s_nxt.mlvl = ~s_r.msync2;
		end
		// Compare to the previous level; ring counts only when it drops
		ev                  = s_nxt.mlvl ^ s_r.mlvl;
		ev[spm_pkg::M_RING] = s_r.mlvl[spm_pkg::M_RING] && !s_nxt.mlvl[spm_pkg::M_RING];
		// Read clears, a change in the same cycle still lands
		s_nxt.mdelta = (rd_msr ? 4'h0 : s_r.mdelta) | ev;

		// Reference tick from the system clock, then divisor to 16x rate
		if (acc_sum >= spm_pkg::ACC_WRAP) begin
			s_nxt.acc = 27'(acc_sum - spm_pkg::ACC_WRAP);
			if (s_r.div != 16'h0000) begin
				if (s_r.bcnt >= s_r.div - 16'h0001) begin
					s_nxt.bcnt = 16'h0000;
					b16        = 1'b1;
				end else begin
					s_nxt.bcnt = s_r.bcnt + 16'h0001;
				end
			end
		end else begin
			s_nxt.acc = acc_sum[26:0];
		end

		// CPU writes
		if (io_wr_i) begin
			case (io_addr_i)
				spm_pkg::ADDR_BASE: if (dls) begin
					s_nxt.div[7:0] = io_wdata_i;
				end
				spm_pkg::ADDR_IER: if (dls) begin
					s_nxt.div[15:8] = io_wdata_i;
				end else begin
					s_nxt.ier = io_wdata_i[3:0];
				end
				spm_pkg::ADDR_LCR: s_nxt.lcr = io_wdata_i;
				spm_pkg::ADDR_MCR: s_nxt.modem_control = io_wdata_i[4:0];
				default: ;
			endcase
		end

		// CPU reads; side effects first so hardware sets win below
		s_nxt.rvalid = io_rd_i;
		if (io_rd_i) begin
			case (io_addr_i)
				spm_pkg::ADDR_BASE: if (dls) begin
					s_nxt.rdata = s_r.div[7:0];
				end else begin
					s_nxt.rdata = s_r.receive_buffer;
					s_nxt.dr    = 1'b0;
				end
				spm_pkg::ADDR_IER: s_nxt.rdata = dls ? s_r.div[15:8] : {4'h0, s_r.ier};
				spm_pkg::ADDR_LCR: s_nxt.rdata = s_r.lcr;
				spm_pkg::ADDR_MCR: s_nxt.rdata = {3'b000, s_r.modem_control};
				spm_pkg::ADDR_LSR: begin
					s_nxt.rdata = {1'b0, !f_valid && (s_r.tx_st == spm_pkg::SER_IDLE),
						f_ready, s_r.bi, s_r.fe, s_r.pe, s_r.oe, s_r.dr};
					s_nxt.oe = 1'b0;
					s_nxt.pe = 1'b0;
					s_nxt.fe = 1'b0;
					s_nxt.bi = 1'b0;
				end
				spm_pkg::ADDR_MSR: s_nxt.rdata = {s_r.mlvl, s_r.mdelta};
				default:           s_nxt.rdata = spm_pkg::UNMAPPED;
			endcase
		end

		// Transmitter line level for the current state; mark if the code is lost
		tx_line = 1'b1;
		unique case (s_r.tx_st)
			spm_pkg::SER_IDLE:   tx_line = 1'b1;
			spm_pkg::SER_START:  tx_line = 1'b0;
			spm_pkg::SER_DATA:   tx_line = s_r.tx_shift[0];
			spm_pkg::SER_PARITY: tx_line = s_r.tx_pbit;
			spm_pkg::SER_STOP:   tx_line = 1'b1;
		endcase

		// Transmitter sequencing, 16 ticks per bit
		if (b16 && s_r.tx_st != spm_pkg::SER_IDLE) begin
			s_nxt.tx_cnt = s_r.tx_cnt + 4'h1;
		end
		unique case (s_r.tx_st)
			spm_pkg::SER_IDLE: if (f_valid) begin
				f_take         = 1'b1;
				s_nxt.tx_shift = f_data & wmask;
				s_nxt.tx_pbit  = s_r.lcr[spm_pkg::LCR_STICK] ? !s_r.lcr[spm_pkg::LCR_EVEN]
					: (^(f_data & wmask)) ^ !s_r.lcr[spm_pkg::LCR_EVEN];
				s_nxt.tx_cnt   = 4'h0;
				s_nxt.tx_bits  = 4'h0;
				s_nxt.tx_st    = spm_pkg::SER_START;
			end
			spm_pkg::SER_START: if (b16 && s_r.tx_cnt == spm_pkg::TICK_LAST) begin
				s_nxt.tx_st = spm_pkg::SER_DATA;
			end
			spm_pkg::SER_DATA: if (b16 && s_r.tx_cnt == spm_pkg::TICK_LAST) begin
				s_nxt.tx_shift = {1'b0, s_r.tx_shift[7:1]};
				s_nxt.tx_bits  = s_r.tx_bits + 4'h1;
				if (s_r.tx_bits == nbits - 4'h1) begin
					s_nxt.tx_bits = 4'h0;
					s_nxt.tx_st   = s_r.lcr[spm_pkg::LCR_PAR_EN] ? spm_pkg::SER_PARITY
						: spm_pkg::SER_STOP;
				end
			end
			spm_pkg::SER_PARITY: if (b16 && s_r.tx_cnt == spm_pkg::TICK_LAST) begin
				s_nxt.tx_st = spm_pkg::SER_STOP;
			end
			spm_pkg::SER_STOP: if (b16 && s_r.tx_cnt == spm_pkg::TICK_LAST) begin
				s_nxt.tx_bits = s_r.tx_bits + 4'h1;
				if (s_r.tx_bits == {3'b000, s_r.lcr[spm_pkg::LCR_STOP2]}) begin
					s_nxt.tx_st = spm_pkg::SER_IDLE;
				end
			end
		endcase

		// Receiver input: own transmitter in loopback
		rx_in = s_r.modem_control[spm_pkg::MCR_LOOP] ? tx_line : s_r.rx_s2;
		if (b16 && s_r.rx_st != spm_pkg::SER_IDLE) begin
			s_nxt.rx_cnt = s_r.rx_cnt + 4'h1;
		end
		unique case (s_r.rx_st)
			spm_pkg::SER_IDLE: if (!rx_in) begin
				s_nxt.rx_cnt = 4'h0;
				s_nxt.rx_st  = spm_pkg::SER_START;
			end
			// Mid-bit recheck filters glitches on the start edge
			spm_pkg::SER_START: if (b16 && s_r.rx_cnt == spm_pkg::TICK_MID) begin
				s_nxt.rx_cnt  = 4'h0;
				s_nxt.rx_bits = 4'h0;
				s_nxt.rx_par  = 1'b0;
				s_nxt.rx_perr = 1'b0;
				s_nxt.rx_st   = rx_in ? spm_pkg::SER_IDLE : spm_pkg::SER_DATA;
			end
			spm_pkg::SER_DATA: if (b16 && s_r.rx_cnt == spm_pkg::TICK_LAST) begin
				s_nxt.rx_shift = {rx_in, s_r.rx_shift[7:1]};
				s_nxt.rx_par   = s_r.rx_par ^ rx_in;
				s_nxt.rx_bits  = s_r.rx_bits + 4'h1;
				if (s_r.rx_bits == nbits - 4'h1) begin
					s_nxt.rx_st = s_r.lcr[spm_pkg::LCR_PAR_EN] ? spm_pkg::SER_PARITY
						: spm_pkg::SER_STOP;
				end
			end
			spm_pkg::SER_PARITY: if (b16 && s_r.rx_cnt == spm_pkg::TICK_LAST) begin
				s_nxt.rx_perr = rx_in != (s_r.lcr[spm_pkg::LCR_STICK]
					? !s_r.lcr[spm_pkg::LCR_EVEN] : s_r.rx_par ^ !s_r.lcr[spm_pkg::LCR_EVEN]);
				s_nxt.rx_st   = spm_pkg::SER_STOP;
			end
			spm_pkg::SER_STOP: if (b16 && s_r.rx_cnt == spm_pkg::TICK_LAST) begin
				s_nxt.receive_buffer   = s_r.rx_shift >> (4'd8 - nbits);
				s_nxt.oe    = s_nxt.oe || s_nxt.dr;
				s_nxt.dr    = 1'b1;
				s_nxt.pe    = s_nxt.pe || s_r.rx_perr;
				s_nxt.fe    = s_nxt.fe || !rx_in;
				s_nxt.bi    = s_nxt.bi || (!rx_in && s_r.rx_shift == 8'h00);
				s_nxt.rx_st = spm_pkg::SER_IDLE;
			end
		endcase

		// Registered outputs; loopback parks the line and modem outputs
		s_nxt.txd = s_r.modem_control[spm_pkg::MCR_LOOP] ? 1'b1
			: (s_r.lcr[spm_pkg::LCR_BREAK] ? 1'b0 : tx_line);
		s_nxt.mout_n = s_nxt.modem_control[spm_pkg::MCR_LOOP] ? 4'hF : ~s_nxt.modem_control[3:0];
		s_nxt.irq    = (|s_nxt.mdelta) && s_nxt.ier[spm_pkg::IER_MODEM];
	end

	// State register; modem pins idle high at reset
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s_r        <= '0;
			s_r.msync1 <= 4'hF;
			s_r.msync2 <= 4'hF;
			s_r.rx_s1  <= 1'b1;
			s_r.rx_s2  <= 1'b1;
			s_r.lcr    <= spm_pkg::LCR_RST;
			s_r.modem_control    <= spm_pkg::MCR_RST;
			s_r.ier    <= spm_pkg::IER_RST;
			s_r.div    <= spm_pkg::DIV_RST;
			s_r.txd    <= 1'b1;
			s_r.mout_n <= 4'hF;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from flops
	assign io_rdata_o          = s_r.rdata;
	assign io_rvalid_o         = s_r.rvalid;
	assign txd_o               = s_r.txd;
	assign terminal_ready_n_o  = s_r.mout_n[spm_pkg::MCR_DTR];
	assign request_to_send_n_o = s_r.mout_n[spm_pkg::MCR_RTS];
	assign aux_output_one_n_o  = s_r.mout_n[spm_pkg::MCR_AUX1];
	assign aux_output_two_n_o  = s_r.mout_n[spm_pkg::MCR_AUX2];
	assign modem_irq_o         = s_r.irq;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	property p_cts_flag;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		$changed(s_r.mlvl[0]) |-> s_r.mdelta[0];
	endproperty
	a_cts_flag: assert property (p_cts_flag) else $error("cts change not flagged");

	property p_carrier_flag;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		$changed(s_r.mlvl[3]) |-> s_r.mdelta[3];
	endproperty
	a_carrier_flag: assert property (p_carrier_flag) else $error("carrier change lost");

	property p_ring_fall;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		$fell(s_r.mlvl[2]) |-> s_r.mdelta[2];
	endproperty
	a_ring_fall: assert property (p_ring_fall) else $error("ring trailing edge lost");

	property p_ring_rise;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		$rose(s_r.mlvl[2]) |-> s_r.mdelta[2] == ($past(s_r.mdelta[2]) && !$past(rd_msr));
	endproperty
	a_ring_rise: assert property (p_ring_rise) else $error("ring leading edge flagged");

	property p_msr_clear;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(rd_msr && ev == 4'h0) |=> s_r.mdelta == 4'h0;
	endproperty
	a_msr_clear: assert property (p_msr_clear) else $error("flags kept after read");

	property p_irq;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		modem_irq_o == ((|s_r.mdelta) && s_r.ier[spm_pkg::IER_MODEM]);
	endproperty
	a_irq: assert property (p_irq) else $error("modem irq mismatch");

	property p_levels;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		($past(resetn_i, 3) && !$past(s_r.modem_control[spm_pkg::MCR_LOOP])) |-> s_r.mlvl ==
			~{$past(carrier_detect_n_i, 3), $past(ring_n_i, 3),
			$past(set_ready_n_i, 3), $past(clear_to_send_n_i, 3)};
	endproperty
	a_levels: assert property (p_levels) else $error("modem level wrong");

	property p_loop_levels;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		$past(s_r.modem_control[spm_pkg::MCR_LOOP]) |-> s_r.mlvl ==
			{$past(s_r.modem_control[3]), $past(s_r.modem_control[2]), $past(s_r.modem_control[0]), $past(s_r.modem_control[1])};
	endproperty
	a_loop_levels: assert property (p_loop_levels) else $error("loop level wrong");

	property p_tx_bit;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(s_r.tx_st == spm_pkg::SER_DATA && !s_r.lcr[6] && !s_r.modem_control[4])
			|=> txd_o == $past(s_r.tx_shift[0]);
	endproperty
	a_tx_bit: assert property (p_tx_bit) else $error("tx data bit wrong");

	property p_break;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(s_r.lcr[spm_pkg::LCR_BREAK] && !s_r.modem_control[spm_pkg::MCR_LOOP]) |=> !txd_o;
	endproperty
	a_break: assert property (p_break) else $error("break not driven");

	property p_rbr_read;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(io_rd_i && io_addr_i == spm_pkg::ADDR_BASE && !dls)
			|=> io_rvalid_o && io_rdata_o == $past(s_r.receive_buffer);
	endproperty
	a_rbr_read: assert property (p_rbr_read) else $error("receive read wrong");

	property p_div_low;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(io_wr_i && io_addr_i == spm_pkg::ADDR_BASE && dls)
			|=> s_r.div[7:0] == $past(io_wdata_i)
			&& u_tx_fifo.s_r.cnt <= $past(u_tx_fifo.s_r.cnt);
	endproperty
	a_div_low: assert property (p_div_low) else $error("divisor low not written");

	property p_div_high;
		@(posedge sys_clk_i) disable iff (!resetn_i)
		(io_wr_i && io_addr_i == spm_pkg::ADDR_IER && dls)
			|=> s_r.div[15:8] == $past(io_wdata_i);
	endproperty
	a_div_high: assert property (p_div_high) else $error("divisor high not written");

endmodule

// >>> tb/spm_modem.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far-side modem and serial peer
// ----------------------------------------------------------------
module spm_modem #(
	parameter int BIT_CYC = 868
) (
	// Clock
	input  wire logic       sys_clk_i,
	// Serial lines
	input  wire logic       txd_i,
	output logic            rxd_o,
	// Modem lines, active low: carrier, ring, set ready, clear to send
	output logic      [3:0] lines_n_o
);
	// Mark level and inactive lines until told otherwise
	initial begin
		rxd_o     = 1'b1;
		lines_n_o = 4'hF;
	end

	// One line moves just after an edge
	task automatic set_line(input int i, input logic v);
		@(posedge sys_clk_i);
		lines_n_o[i] <= v;
	endtask

	// Start, eight data bits LSB first, one stop bit
	task automatic send(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int k = 0; k < 10; k++) begin
			@(posedge sys_clk_i);
			rxd_o <= f[k];
			repeat (BIT_CYC - 1) @(posedge sys_clk_i);
		end
	endtask

	// Mid-bit sampling; bounded wait so a silent line cannot hang us
	task automatic grab(output logic [7:0] c, output logic stp);
		int n;
		n = 0;
		while (txd_i !== 1'b0 && n < 20000) begin
			@(posedge sys_clk_i);
			n++;
		end
		repeat (BIT_CYC / 2) @(posedge sys_clk_i);
		for (int k = 0; k < 8; k++) begin
			repeat (BIT_CYC) @(posedge sys_clk_i);
			c[k] = txd_i;
		end
		repeat (BIT_CYC) @(posedge sys_clk_i);
		stp = txd_i;
	endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic       sys_clk_i, resetn_i, io_rd_i, io_wr_i, io_rvalid_o;
	logic       rxd_i, txd_o, modem_irq_o, s;
	logic [9:0] io_addr_i;
	logic [7:0] io_wdata_i, io_rdata_o, d, b;
	logic [3:0] ln_n, mo_n, m;
	int         error_cnt, tests_run, cyc;
	logic [7:0] tx [4] = '{8'h5A, 8'hC3, 8'h01, 8'h80};

	spm_uart DUT (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .io_addr_i(io_addr_i),
		.io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i),
		.io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .rxd_i(rxd_i), .txd_o(txd_o),
		.clear_to_send_n_i(ln_n[0]), .set_ready_n_i(ln_n[1]), .ring_n_i(ln_n[2]),
		.carrier_detect_n_i(ln_n[3]), .request_to_send_n_o(mo_n[3]),
		.terminal_ready_n_o(mo_n[2]), .aux_output_one_n_o(mo_n[1]),
		.aux_output_two_n_o(mo_n[0]), .modem_irq_o(modem_irq_o));

	// Divisor 1 keeps each bit near 868 system clocks
	spm_modem #(.BIT_CYC(868)) MDM (.sys_clk_i(sys_clk_i), .txd_i(txd_o), .rxd_o(rxd_i),
		.lines_n_o(ln_n));

	// ----------------------------------------------------------------
	// Clock and hang guard
	// ----------------------------------------------------------------
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// Four frames and one receive need well under this
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Port tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		io_wr_i    <= 1'b1;
		io_addr_i  <= a;
		io_wdata_i <= v;
		@(posedge sys_clk_i);
		io_wr_i <= 1'b0;
	endtask

	// Answer lands on the taking edge; look just after it
	task automatic rd(input logic [9:0] a);
		@(posedge sys_clk_i);
		io_rd_i   <= 1'b1;
		io_addr_i <= a;
		@(posedge sys_clk_i);
		io_rd_i <= 1'b0;
		#1;
		chk({7'h00, io_rvalid_o}, 8'h01);
		d = io_rdata_o;
	endtask

	task automatic rc(input logic [9:0] a, input logic [7:0] exp);
		rd(a);
		chk(d, exp);
	endtask

	task automatic settle();
		repeat (5) @(posedge sys_clk_i);
	endtask

	task automatic test_done();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		resetn_i   = 1'b0;
		io_rd_i    = 1'b0;
		io_wr_i    = 1'b0;
		io_addr_i  = 10'h000;
		io_wdata_i = 8'h00;
		error_cnt  = 0;
		tests_run  = 0;
		cyc        = 0;
		repeat (3) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		rc(spm_pkg::ADDR_MSR, 8'h00);
		rc(spm_pkg::ADDR_LCR, spm_pkg::LCR_RST);
		rc(10'h3FA, spm_pkg::UNMAPPED);
		// Each line in turn: assert, read twice, release, read
		wr(spm_pkg::ADDR_IER, 8'h08);
		for (int i = 0; i < 4; i++) begin
			m = 4'(1 << i);
			MDM.set_line(i, 1'b0);
			settle();
			chk({7'h00, modem_irq_o}, {7'h00, 1'(i != 2)});
			rc(spm_pkg::ADDR_MSR, {m, (i == 2) ? 4'h0 : m});
			rc(spm_pkg::ADDR_MSR, {m, 4'h0});
			MDM.set_line(i, 1'b1);
			settle();
			rc(spm_pkg::ADDR_MSR, {4'h0, m});
			chk({7'h00, modem_irq_o}, 8'h00);
		end
		// Masked: flag still set, no request
		wr(spm_pkg::ADDR_IER, 8'h00);
		MDM.set_line(3, 1'b0);
		settle();
		chk({7'h00, modem_irq_o}, 8'h00);
		rc(spm_pkg::ADDR_MSR, 8'h88);
		MDM.set_line(3, 1'b1);
		// Carrier release must land before loopback hides the pin
		settle();
		// Loopback: levels and flags follow modem control
		wr(spm_pkg::ADDR_MCR, 8'h1F);
		settle();
		chk({3'h0, txd_o, mo_n}, 8'h1F);
		rc(spm_pkg::ADDR_MSR, 8'hFB);
		wr(spm_pkg::ADDR_MCR, 8'h11);
		settle();
		rc(spm_pkg::ADDR_MSR, 8'h2D);
		wr(spm_pkg::ADDR_MCR, 8'h03);
		settle();
		chk({3'h0, txd_o, mo_n}, 8'h13);
		// Divisor halves; high byte nonzero to catch a swap
		wr(spm_pkg::ADDR_LCR, 8'h80);
		wr(spm_pkg::ADDR_BASE, 8'h0C);
		wr(spm_pkg::ADDR_IER, 8'h5A);
		rc(spm_pkg::ADDR_BASE, 8'h0C);
		rc(spm_pkg::ADDR_IER, 8'h5A);
		wr(spm_pkg::ADDR_BASE, 8'h01);
		wr(spm_pkg::ADDR_IER, 8'h00);
		// Parity off, so even and stick bits must not add a bit
		wr(spm_pkg::ADDR_LCR, 8'h33);
		rc(spm_pkg::ADDR_LCR, 8'h33);
		rc(spm_pkg::ADDR_LSR, 8'h60);
		foreach (tx[k]) wr(spm_pkg::ADDR_BASE, tx[k]);
		foreach (tx[k]) begin
			MDM.grab(b, s);
			chk(b, tx[k]);
			chk({7'h00, s}, 8'h01);
		end
		wr(spm_pkg::ADDR_LCR, 8'h73);
		settle();
		chk({7'h00, txd_o}, 8'h00);
		wr(spm_pkg::ADDR_LCR, 8'h33);
		settle();
		chk({7'h00, txd_o}, 8'h01);
		// Receive path, polled through line status first
		MDM.send(8'hA5);
		rd(spm_pkg::ADDR_LSR);
		chk(d & 8'h01, 8'h01);
		rc(spm_pkg::ADDR_BASE, 8'hA5);
		test_done();
	end
endmodule
